// *** verilog/scg_clock_gen.sv ***
// file: top of system clock generation (source select, divider, trim, clock out)
//
// Contract
// - oscillator clock comes from exactly one of four sources
// - source choice comes from non-volatile configuration, not register writes
// - cpu clock is a programmable divider output fed by source clock
// - one machine cycle is two cpu clock cycles
// - peripheral clock runs at half the cpu clock
// - rc oscillator nominal 7.373 MHz at factory trim
// - watchdog oscillator runs independently near 400 kHz, selectable
// - crystal offers low, medium and high speed ranges
// - clock pin drives only if enabled, no crystal source, no crystal rtc
// - enabled clock pin toggles at half the cpu clock
// - six-bit writable trim tunes the rc oscillator
// - only power-on reset loads factory trim value
// - clock pin enable is bit 6 of the trim register
`timescale 1ns/100ps
module scg_clock_gen (
  // clock and resets
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       por_n,
  // oscillator source ticks, one sys_clk pulse per source edge, plus the external clock pin level
  input  wire logic       wdog_osc_tick,
  input  wire logic       rc_osc_tick,
  input  wire logic       xtal_osc_tick,
  input  wire logic       osc_input_pin,
  // non-volatile configuration
  input  wire logic [1:0] cfg_source,
  input  wire logic [1:0] cfg_xtal_range,
  input  wire logic       cfg_rtc_uses_xtal,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic [7:0]      sfr_rdata,
  // clock enables
  output logic            selected_source_clock,
  output logic            cpu_core_clock,
  output logic            machine_cycle_en,
  output logic            periph_clock_en,
  // rc oscillator tuning and crystal range
  output logic [5:0]      rc_trim_value,
  output logic [1:0]      xtal_range_sel,
  // half-rate clock pin
  output logic            half_rate_clock_pin,
  output logic            half_rate_clock_oe
);
  // ==========================================================
  // pin synchroniser for the external clock input
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= osc_input_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end
  // rising edge of the external clock; each pin level must last at least one sys_clk cycle to be seen
  logic ext_tick;
  assign ext_tick = ext_s2_reg & ~ext_s3_reg;

  // ==========================================================
  // source capture: configuration is latched once after reset release
  scg_pkg::scg_state_t state_reg;
  scg_pkg::scg_state_t state_next;
  logic [1:0]          src_reg;
  logic [1:0]          src_next;
  logic [1:0]          range_reg;
  logic [1:0]          range_next;
  logic                rtcx_reg;
  logic                rtcx_next;

  // later configuration changes are ignored until the next reset
  always_comb begin
    state_next = state_reg;
    src_next   = src_reg;
    range_next = range_reg;
    rtcx_next  = rtcx_reg;
    case (state_reg)
      scg_pkg::SCG_CFG: begin
        src_next   = cfg_source;
        range_next = cfg_xtal_range;
        rtcx_next  = cfg_rtc_uses_xtal;
        state_next = scg_pkg::SCG_RUN;
      end
      scg_pkg::SCG_RUN: begin
        state_next = scg_pkg::SCG_RUN;
      end
      default: begin
        state_next = scg_pkg::SCG_CFG;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= scg_pkg::SCG_CFG;
      src_reg   <= scg_pkg::SRC_RC;
      range_reg <= scg_pkg::XR_LOW;
      rtcx_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      src_reg   <= src_next;
      range_reg <= range_next;
      rtcx_reg  <= rtcx_next;
    end
  end

  // ==========================================================
  // source multiplexer: exactly one source feeds the divider
  logic osc_tick;
  logic running;
  assign running = (state_reg == scg_pkg::SCG_RUN);
  always_comb begin
    case (src_reg)
      scg_pkg::SRC_XTAL: osc_tick = xtal_osc_tick;
      scg_pkg::SRC_EXT:  osc_tick = ext_tick;
      scg_pkg::SRC_WDOG: osc_tick = wdog_osc_tick;
      scg_pkg::SRC_RC:   osc_tick = rc_osc_tick;
      default:           osc_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // trim register: factory value only on power-on reset
  logic [7:0] tune_reg;
  logic [7:0] tune_next;
  logic       tune_hit;
  assign tune_hit = sfr_wr && (sfr_addr == scg_pkg::TUNE_ADDR);
  always_comb begin
    tune_next = tune_reg;
    if (tune_hit) begin
      tune_next = sfr_wdata;
    end
  end
  // reset by por_n only, so a warm reset keeps the tuning
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      tune_reg <= {2'h0, scg_pkg::TRIM_FACTORY};
    end else begin
      tune_reg <= tune_next;
    end
  end

  // ==========================================================
  // cpu clock divider register
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       cpu_core_clock_reg;
  logic       cpu_core_clock_next;
  always_comb begin
    div_next  = div_reg;
    cnt_next  = cnt_reg;
    cpu_core_clock_next = 1'b0;
    if (sfr_wr && (sfr_addr == scg_pkg::DIV_ADDR)) begin
      div_next = sfr_wdata;
      cnt_next = 8'h00;  // restart so a new ratio applies at once
    end else if (running && osc_tick) begin
      if (div_reg == 8'h00) begin
        cpu_core_clock_next = 1'b1;
      end else if (cnt_reg >= div_reg) begin
        cnt_next  = 8'h00;
        cpu_core_clock_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= scg_pkg::DIV_RESET;
      cnt_reg  <= 8'h00;
      cpu_core_clock_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      cnt_reg  <= cnt_next;
      cpu_core_clock_reg <= cpu_core_clock_next;
    end
  end

  // ==========================================================
  // half-rate derivations from the cpu clock enable
  logic mc_q;
  logic mc_pulse;
  logic pin_half;
  logic pin_allowed;
  logic pin_clear;
  scg_toggle u_machine (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .tick_en    (cpu_core_clock_reg),
    .clear      (1'b0),
    .half_q     (mc_q),
    .half_pulse (mc_pulse)
  );
  // pin divider is held clear while disabled so it starts from low
  assign pin_allowed = tune_reg[scg_pkg::PIN_EN_BIT] && (src_reg != scg_pkg::SRC_XTAL)
                       && !rtcx_reg && running;
  assign pin_clear   = !pin_allowed;
  scg_toggle u_clk_pin (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .tick_en    (cpu_core_clock_reg),
    .clear      (pin_clear),
    .half_q     (pin_half),
    .half_pulse ()
  );

  // ==========================================================
  // registered outputs
  logic       oe_reg;
  logic       pin_reg;
  logic       src_tick_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;  // unmapped addresses read zero
    if (sfr_rd && (sfr_addr == scg_pkg::TUNE_ADDR)) begin
      rdata_next = tune_reg;
    end else if (sfr_rd && (sfr_addr == scg_pkg::DIV_ADDR)) begin
      rdata_next = div_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg       <= 1'b0;
      pin_reg      <= 1'b0;
      src_tick_reg <= 1'b0;
      rdata_reg    <= 8'h00;
    end else begin
      oe_reg       <= pin_allowed;
      pin_reg      <= pin_half & pin_allowed;
      src_tick_reg <= running & osc_tick;
      rdata_reg    <= rdata_next;
    end
  end

  // rc trim and range leave straight from their registers
  assign rc_trim_value         = tune_reg[scg_pkg::TRIM_W-1:0];
  assign xtal_range_sel        = range_reg;
  assign sfr_rdata             = rdata_reg;
  assign selected_source_clock = src_tick_reg;
  assign cpu_core_clock        = cpu_core_clock_reg;
  assign machine_cycle_en      = mc_pulse;
  assign periph_clock_en       = mc_pulse;
  assign half_rate_clock_pin   = pin_reg;
  assign half_rate_clock_oe    = oe_reg;
endmodule : scg_clock_gen

// *** verilog/scg_pkg.sv ***
// package: constants for the system clock generation block
package scg_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] TUNE_ADDR       = 8'h96;  // rc_oscillator_tune
  localparam logic [7:0] DIV_ADDR        = 8'h95;  // cpu_clock_divider
  localparam int         TRIM_W          = 6;
  localparam int         PIN_EN_BIT      = 6;
  localparam int         RC_OUT_BIT      = 7;
  localparam logic [5:0] TRIM_FACTORY    = 6'h20;  // arbitrary factory trim default
  localparam logic [7:0] DIV_RESET       = 8'h00;
  // ==========================================================
  // oscillator source codes held in configuration
  localparam logic [1:0] SRC_XTAL        = 2'h0;
  localparam logic [1:0] SRC_EXT         = 2'h1;
  localparam logic [1:0] SRC_WDOG        = 2'h2;
  localparam logic [1:0] SRC_RC          = 2'h3;
  // crystal range codes
  localparam logic [1:0] XR_LOW          = 2'h0;   // 20 kHz .. 100 kHz
  localparam logic [1:0] XR_MED          = 2'h1;   // 100 kHz .. 4 MHz
  localparam logic [1:0] XR_HIGH         = 2'h2;   // 4 MHz .. 18 MHz
  // nominal rates and limits in kHz
  localparam int         RC_NOM_KHZ      = 7373;
  localparam int         WDOG_NOM_KHZ    = 400;
  localparam int         EXT_MAX_KHZ     = 18000;
  localparam int         RST_PIN_KHZ     = 12000;
  // ==========================================================
  // state machine for source capture
  typedef enum logic [1:0] {
    SCG_CFG = 2'b01,
    SCG_RUN = 2'b10
  } scg_state_t;
endpackage : scg_pkg

// *** verilog/scg_toggle.sv ***
// file: enable-driven toggle divider used for the half-rate clocks
`timescale 1ns/100ps
module scg_toggle (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control
  input  wire logic tick_en,
  input  wire logic clear,
  // result
  output logic      half_q,
  output logic      half_pulse
);
  logic half_reg;
  logic half_next;
  logic pulse_reg;
  logic pulse_next;

  // ==========================================================
  // next state: clear wins, else flip on every tick and pulse on falling half
  always_comb begin
    half_next  = half_reg;
    pulse_next = 1'b0;
    if (clear) begin
      half_next = 1'b0;
    end else if (tick_en) begin
      half_next  = ~half_reg;
      pulse_next = half_reg;  // every second tick
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      half_reg  <= half_next;
      pulse_reg <= pulse_next;
    end
  end

  assign half_q     = half_reg;
  assign half_pulse = pulse_reg;
endmodule : scg_toggle

// *** test/scg_clock_gen_monitor.sv ***
// checker: port assertions for the clock generation block
`timescale 1ns/100ps
module scg_clock_gen_monitor (
  // watched ports
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       selected_source_clock,
  input wire logic       cpu_core_clock,
  input wire logic       machine_cycle_en,
  input wire logic       periph_clock_en,
  input wire logic [5:0] rc_trim_value,
  input wire logic       half_rate_clock_pin,
  input wire logic       half_rate_clock_oe
);
  // ==========================================================
  // divider value as last written, mirrored from the register port
  logic [7:0] div_reg;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) div_reg <= 8'h00;
    else if (sfr_wr && sfr_addr == scg_pkg::DIV_ADDR) div_reg <= sfr_wdata;
  // parity of cpu pulses since reset; the second pulse of each pair opens a machine cycle
  logic cpu_par;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) cpu_par <= 1'b0;
    else if (cpu_core_clock) cpu_par <= ~cpu_par;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // the machine cycle pulse trails the cpu pulse that completes the pair by one cycle
  property p_mc; machine_cycle_en |-> periph_clock_en && $past(cpu_core_clock); endproperty
  a_mc: assert property (p_mc) else $error("machine cycle off a cpu pulse");
  property p_pclk;
    periph_clock_en == ($past(cpu_core_clock) && !cpu_par) && (periph_clock_en == machine_cycle_en);
  endproperty
  a_pclk: assert property (p_pclk) else $error("peripheral pulse not every second cpu pulse");
  // a stable zero divider passes every source tick through
  property p_div0;
    div_reg == 8'h00 && $past(div_reg) == 8'h00 |-> cpu_core_clock == selected_source_clock;
  endproperty
  a_div0: assert property (p_div0) else $error("undivided clock mismatch");
  property p_oe_off;
    sfr_wr && sfr_addr == scg_pkg::TUNE_ADDR && !sfr_wdata[6] |-> ##2 !half_rate_clock_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven while disabled");
  property p_pin_low;
    !half_rate_clock_oe && !$past(half_rate_clock_oe) |-> !half_rate_clock_pin;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin not low when off");
  property p_toggle;
    half_rate_clock_oe && $past(half_rate_clock_oe) && $changed(half_rate_clock_pin)
      |-> $past(cpu_core_clock, 2);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin toggled without cpu pulse");
  property p_trim;
    sfr_wr && sfr_addr == scg_pkg::TUNE_ADDR |=> rc_trim_value == $past(sfr_wdata[5:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim write lost");
  property p_div_rd;
    sfr_wr && sfr_addr == scg_pkg::DIV_ADDR ##2 sfr_rd && sfr_addr == scg_pkg::DIV_ADDR
      |=> sfr_rdata == $past(sfr_wdata, 3);
  endproperty
  a_div_rd: assert property (p_div_rd) else $error("divider readback wrong");
  c_mc: cover property (machine_cycle_en);
  c_pin: cover property (half_rate_clock_oe && $changed(half_rate_clock_pin));
  c_div: cover property (div_reg != 8'h00 && cpu_core_clock);
endmodule : scg_clock_gen_monitor
bind scg_clock_gen scg_clock_gen_monitor i_mon (.sys_clk, .rst_n, .sfr_addr, .sfr_wdata,
  .sfr_wr, .sfr_rd, .sfr_rdata, .selected_source_clock, .cpu_core_clock, .machine_cycle_en,
  .periph_clock_en, .rc_trim_value, .half_rate_clock_pin, .half_rate_clock_oe);

// *** test/scg_osc_model.sv ***
// model: oscillator sources feeding the clock block
`timescale 1ns/100ps
module scg_osc_model (
  // control
  input  wire logic sys_clk,
  input  wire logic run,
  // source outputs
  output logic      wdog_tick = 1'b0,
  output logic      rc_tick = 1'b0,
  output logic      xtal_tick = 1'b0,
  output logic      ext_pin = 1'b0
);
  // ==========================================================
  // one phase counter; each source ticks at its own fraction of it
  logic [7:0] ph = 8'h00;
  always @(posedge sys_clk) begin
    ph <= ph + 8'h01;
    wdog_tick <= run && ph[3:0] == 4'h0;
    rc_tick <= run && ph[0];
    xtal_tick <= run && ph[1:0] == 2'h1;
    // the external pin stays far below the rate that would need the reset pin function
    ext_pin <= run && ph[2];
  end
endmodule : scg_osc_model

// *** test/scg_clock_gen_tb.sv ***
// bench: random and directed checks of the clock generation block
`timescale 1ns/100ps
module scg_clock_gen_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, run = 1'b0, rtc = 1'b0;
  logic wt, rt, xt, ep, ep_q, ssc, ccc, mce, pce, pin, pin_q, oe, wr = 1'b0, rd = 1'b0;
  logic [1:0] src = 2'h0, xr = 2'h0, xrs, s_cur;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rd_q, tv;
  logic [5:0] trim;
  integer seed = 32'h7279b4d8, r;
  int failures = 0, comparisons = 0, n_in, n_src, n_cpu, n_mc, n_pc, n_pin, d;
  always #25 sys_clk = ~sys_clk;
  scg_osc_model i_osc (.sys_clk(sys_clk), .run(run), .wdog_tick(wt), .rc_tick(rt),
    .xtal_tick(xt), .ext_pin(ep));
  scg_clock_gen i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .wdog_osc_tick(wt),
    .rc_osc_tick(rt), .xtal_osc_tick(xt), .osc_input_pin(ep), .cfg_source(src),
    .cfg_xtal_range(xr), .cfg_rtc_uses_xtal(rtc), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .selected_source_clock(ssc),
    .cpu_core_clock(ccc), .machine_cycle_en(mce), .periph_clock_en(pce),
    .rc_trim_value(trim), .xtal_range_sel(xrs), .half_rate_clock_pin(pin),
    .half_rate_clock_oe(oe));
  // ==========================================================
  // pulse counters, sampled away from the launching edge
  always @(negedge sys_clk) begin
    n_in += int'(s_cur == scg_pkg::SRC_WDOG ? wt : s_cur == scg_pkg::SRC_RC ? rt :
                 s_cur == scg_pkg::SRC_XTAL ? xt : ep && !ep_q);
    ep_q = ep;
    n_src += int'(ssc);
    n_cpu += int'(ccc);
    n_mc += int'(mce);
    n_pc += int'(pce);
    n_pin += int'(pin !== pin_q);
    pin_q = pin;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic sfr(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge sys_clk);
    rd_q = rdata;
  endtask : sfr
  // config is set before release; the first edge after release captures it
  task automatic reset(logic por);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    por_n <= !por;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask : reset
  task automatic measure(logic [1:0] s, int k);
    logic ok;
    r = $random(seed);
    d = k ? int'(r[4:3]) : 0;
    tv = r[15:8] | (k ? 8'h00 : 8'h40);
    @(posedge sys_clk);
    src <= s;
    xr <= r[1:0] % 2'h3;
    rtc <= r[2] && k;
    s_cur = s;
    reset(1'b0);
    sfr(1'b1, scg_pkg::DIV_ADDR, 8'(d));
    sfr(1'b0, scg_pkg::DIV_ADDR, 8'h00);
    chk("div_rd", 16'(rd_q), 16'(d));
    sfr(1'b1, scg_pkg::TUNE_ADDR, tv);
    @(posedge sys_clk);
    src <= ~s; // captured config must not follow the pins
    {n_in, n_src, n_cpu, n_mc, n_pc, n_pin} = '0;
    run <= 1'b1;
    repeat (200) @(posedge sys_clk);
    run <= 1'b0;
    repeat (8) @(posedge sys_clk);
    ok = tv[6] && s != scg_pkg::SRC_XTAL && !rtc;
    chk("src", 16'(n_src), 16'(n_in));
    chk("cpu", 16'(n_cpu), 16'(n_in / (d + 1)));
    chk("mc", 16'(n_mc), 16'(n_in / (d + 1) / 2));
    chk("pc", 16'(n_pc), 16'(n_in / (d + 1) / 2));
    chk("oe", 16'(oe), 16'(ok));
    chk("pin", 16'(n_pin), ok ? 16'(n_in / (d + 1)) : 16'h0000);
    chk("range", 16'(xrs), 16'(r[1:0] % 2'h3));
    chk("trim", 16'(trim), 16'(tv[5:0]));
    $display("test source %0d pass %0d done", s, k);
  endtask : measure
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // main sequence: trim and reset handling, then every source twice
  initial begin
    reset(1'b1);
    sfr(1'b0, scg_pkg::TUNE_ADDR, 8'h00);
    chk("trim_por", 16'(rd_q[5:0]), 16'(scg_pkg::TRIM_FACTORY));
    r = $random(seed);
    sfr(1'b1, scg_pkg::TUNE_ADDR, r[7:0]);
    sfr(1'b0, scg_pkg::TUNE_ADDR, 8'h00);
    chk("trim_rd", 16'(rd_q[5:0]), 16'(r[5:0]));
    reset(1'b0);
    @(negedge sys_clk);
    chk("trim_keep", 16'(trim), 16'(r[5:0]));
    sfr(1'b0, 8'h00, 8'h00);
    chk("unmapped", 16'(rd_q), 16'h0000);
    $display("test trim done");
    for (int s = 0; s < 4; s++) for (int k = 0; k < 2; k++) measure(2'(s), k);
    test_done();
  end
  // watchdog well beyond the expected run of about 1900 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    test_done();
  end
endmodule : scg_clock_gen_tb
